/* logic/seq_smbus_pkg.sv */
// Constants, state type and helpers for the supply sequencer's SMBus memory port.
// Assumes a 20 MHz system clock and an SMBus link clocked by the bus's own SCL.
// Function
// [R1] Volatile registers 0x00-0xDF, byte read/write
// [R2] Program only bytes still erased
// [R3] Erase whole 32-byte pages, 32 pages
// [R4] Erase only when config bit 2 set
// [R5] Send byte loads register address pointer
// [R6] Command 0xFE erases previously addressed page
// [R7] Erase starts at once, NACK for 20 ms
// [R8] Write byte stores data at register
// [R9] Commands 0xF8-0xFB plus byte set pointer
// [R10] Erase page from low byte upper bits
// [R11] Second data byte programs nonvolatile location
// [R12] Block write 0xFC, count up to 32
// [R13] Master presets address, pages pre-erased
// [R14] Stretch SCL while byte programs
// [R15] Receive byte returns pointed location
// [R16] Block read 0xFD returns 0x20 plus 32
// [R17] Master acknowledges block read bytes
// [R18] Optional error check byte after transfers
// [R19] Error check is CRC-8, x8+x2+x+1
// [R20] Master NACKs check byte, retries on error
// [R21] Master NACKs receive byte then stops
// [R22] Bus address 10001 plus two select pins
// [R23] NACK locked range while sequencer runs; a 0xFE erase of a locked page is still ACKed and run
// [R24] Pointer advances per block byte
// [R25] CRC over all bytes, starting zero
package seq_smbus_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int PROG_TIME_NS = 250000;
	localparam int ERASE_TIME_NS = 20000000;
	localparam int NV_AW = 10;
	localparam int NV_DEPTH = 1024;
	localparam int PAGE_BITS = 5;
	localparam int PAGE_SIZE = 32;
	localparam int RAM_DEPTH = 224;
	localparam int CFG_ERASE_EN_BIT = 2;
	localparam logic [4:0] DEV_ADDR_HI = 5'h11;
	localparam logic [7:0] RAM_LAST = 8'hdf;
	localparam logic [7:0] NV_HI_FIRST = 8'hf8;
	localparam logic [7:0] NV_HI_LOCK = 8'hfa;
	localparam logic [7:0] NV_HI_LAST = 8'hfb;
	localparam logic [7:0] CMD_BLK_WR = 8'hfc;
	localparam logic [7:0] CMD_BLK_RD = 8'hfd;
	localparam logic [7:0] CMD_ERASE = 8'hfe;
	localparam logic [7:0] CFG_ADDR = 8'h90;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] BLK_COUNT = 8'h20;
	localparam logic [5:0] BLK_MAX = 6'h20;
	localparam logic [5:0] BLK_PEC_IDX = 6'h21;
	localparam logic [5:0] RD_IDX_SAT = 6'h3f;
	localparam logic [7:0] ERASED = 8'hff;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [3:0] ACK_BIT = 4'h8;

	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_READ, ST_IGNORE} link_state_t;

	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		return c;
	endfunction

	function automatic logic is_nv_hi(input logic [7:0] hi);
		return (hi >= NV_HI_FIRST) && (hi <= NV_HI_LAST);
	endfunction

	function automatic logic is_ram(input logic [15:0] a);
		return (a[15:8] == 8'h00) && (a[7:0] <= RAM_LAST);
	endfunction
endpackage

/* logic/nv_if.sv */
// Carrier between the protocol engine and the nonvolatile array.
// Assumes one clock domain on both sides.
interface nv_if;
	logic [9:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       prog;
	logic       erase;
	logic       prog_busy;
	logic       erase_busy;
	modport ctrl (output addr, wdata, prog, erase, input rdata, prog_busy, erase_busy);
	modport mem  (input addr, wdata, prog, erase, output rdata, prog_busy, erase_busy);
endinterface

/* logic/sda_shift_in.sv */
// SCL-domain receive shifter: samples SDA on each rising SCL edge.
// Assumes the reader takes the byte only while SCL is low after the 8th bit.
module sda_shift_in (
	input  wire logic       scl_clk,
	input  wire logic       sda_in,
	output logic [7:0] rx_byte
);
	// Data only; stable from the 8th rise until the 9th rise
	always_ff @(posedge scl_clk)
	begin
		rx_byte <= {rx_byte[6:0], sda_in};
	end
endmodule

/* logic/nv_array.sv */
// Page-organised nonvolatile array with program and erase busy timing.
// Assumes the controller issues one operation at a time while not busy.
module nv_array #(
	parameter int PROG_CYC  = 5000,
	parameter int ERASE_CYC = 400000
) (
	input  wire logic clk,
	input  wire logic rst,
	nv_if.mem         nv
);
	localparam int CW = $clog2(ERASE_CYC + 1);
	logic [7:0]    mem_arr [0:seq_smbus_pkg::NV_DEPTH-1];
	logic [CW-1:0] cnt_reg;
	logic          active_reg;
	logic          erasing_reg;
	logic          go_erase;
	logic          go_prog;

	assign go_erase = nv.erase && !active_reg;
	assign go_prog = nv.prog && !active_reg;
	assign nv.rdata = mem_arr[nv.addr];
	assign nv.erase_busy = active_reg && erasing_reg;
	assign nv.prog_busy = active_reg && !erasing_reg;

	// Array resets to erased so simulation starts from a known image
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < seq_smbus_pkg::NV_DEPTH; i++)
				mem_arr[i] <= seq_smbus_pkg::ERASED;
		end
		else if (go_erase)
		begin
			for (int j = 0; j < seq_smbus_pkg::PAGE_SIZE; j++) // R3 R10
				mem_arr[{nv.addr[9:5], 5'(j)}] <= seq_smbus_pkg::ERASED;
		end
		else if (go_prog && mem_arr[nv.addr] == seq_smbus_pkg::ERASED) // R2
			mem_arr[nv.addr] <= nv.wdata;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_reg <= '0;
			active_reg <= 1'b0;
			erasing_reg <= 1'b0;
		end
		else if (go_erase || go_prog)
		begin
			cnt_reg <= go_erase ? CW'(ERASE_CYC - 1) : CW'(PROG_CYC - 1);
			active_reg <= 1'b1;
			erasing_reg <= go_erase;
		end
		else if (cnt_reg != '0)
			cnt_reg <= cnt_reg - CW'(1);
		else
			active_reg <= 1'b0;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_prog_blank_only: assert property ( // R2
		go_prog && !go_erase && mem_arr[nv.addr] != seq_smbus_pkg::ERASED
		|=> mem_arr[$past(nv.addr)] == $past(mem_arr[nv.addr]))
		else $error("programmed a location that was not erased");
	a_erase_page_top: assert property ( // R3
		go_erase |=> mem_arr[{$past(nv.addr[9:5]), 5'h1f}] == seq_smbus_pkg::ERASED && nv.erase_busy)
		else $error("page erase incomplete");
endmodule

/* logic/seq_smbus_top.sv */
// SMBus slave for register RAM, nonvolatile array access and page erase.
// Assumes SCL and SDA are open-drain; scl_clk is the SCL pin used as a clock.
module seq_smbus_top #(
	parameter int PROG_CYC  = seq_smbus_pkg::PROG_TIME_NS / seq_smbus_pkg::CLK_PERIOD_NS,
	parameter int ERASE_CYC = seq_smbus_pkg::ERASE_TIME_NS / seq_smbus_pkg::CLK_PERIOD_NS
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic scl_clk,
	input  wire logic scl_in,
	output logic      scl_out,
	output logic      scl_oe,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	input  wire logic bus_addr_select_hi,
	input  wire logic bus_addr_select_lo,
	input  wire logic seq_running
);
	seq_smbus_pkg::link_state_t state_reg;
	seq_smbus_pkg::link_state_t st_next;
	logic [2:0]  scl_sync;
	logic [2:0]  sda_sync;
	logic [1:0]  sel_hi_sync;
	logic [1:0]  sel_lo_sync;
	logic [1:0]  run_sync;
	logic [3:0]  cnt_reg;
	logic [5:0]  dcnt_reg;
	logic [5:0]  blk_len_reg;
	logic [5:0]  rd_idx_reg;
	logic [7:0]  cmd_reg;
	logic [15:0] ptr_reg;
	logic [15:0] ptr_next;
	logic [15:0] ptr_rd_next;
	logic [7:0]  tx_reg;
	logic [7:0]  crc_reg;
	logic [7:0]  cfg_reg;
	logic        blk_rd_reg;
	logic        sda_oe_reg;
	logic        scl_oe_reg;
	logic [7:0]  ram_mem [0:seq_smbus_pkg::RAM_DEPTH-1];
	logic [7:0]  rx_byte;
	logic [6:0]  own_addr;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_cond;
	logic        stop_cond;
	logic        write_dir;
	logic        byte_done_w;
	logic        read_load_w;
	logic        ack;
	logic        ram_we;
	logic [7:0]  ram_wa;
	logic [7:0]  ram_rd;
	logic [7:0]  rd_byte;
	logic [7:0]  rd_next;
	logic        nv_prog;
	logic        nv_erase;
	logic        pec_ok;

	nv_if nv ();

	sda_shift_in u_shift (
		.scl_clk (scl_clk),
		.sda_in  (sda_in),
		.rx_byte (rx_byte)
	);

	nv_array #(
		.PROG_CYC  (PROG_CYC),
		.ERASE_CYC (ERASE_CYC)
	) u_nv (
		.clk (clk),
		.rst (rst),
		.nv  (nv)
	);

	function automatic logic nv_locked(input logic [15:0] p, input logic run);
		return run && seq_smbus_pkg::is_nv_hi(p[15:8]) && (p[15:8] >= seq_smbus_pkg::NV_HI_LOCK);
	endfunction

	// Pins cross into clk through two flops; bit 2 is edge history
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			sel_hi_sync <= 2'h0;
			sel_lo_sync <= 2'h0;
			run_sync <= 2'h0;
		end
		else
		begin
			scl_sync <= {scl_sync[1:0], scl_in};
			sda_sync <= {sda_sync[1:0], sda_in};
			sel_hi_sync <= {sel_hi_sync[0], bus_addr_select_hi};
			sel_lo_sync <= {sel_lo_sync[0], bus_addr_select_lo};
			run_sync <= {run_sync[0], seq_running};
		end
	end

	assign scl_rise = scl_sync[1] && !scl_sync[2];
	assign scl_fall = !scl_sync[1] && scl_sync[2];
	assign start_cond = scl_sync[1] && scl_sync[2] && !sda_sync[1] && sda_sync[2];
	assign stop_cond = scl_sync[1] && scl_sync[2] && sda_sync[1] && !sda_sync[2];
	assign own_addr = {seq_smbus_pkg::DEV_ADDR_HI, sel_hi_sync[1], sel_lo_sync[1]}; // R22
	assign write_dir = state_reg == seq_smbus_pkg::ST_ADDR || state_reg == seq_smbus_pkg::ST_CMD
		|| state_reg == seq_smbus_pkg::ST_DATA;
	assign byte_done_w = scl_fall && cnt_reg == seq_smbus_pkg::ACK_BIT;
	assign read_load_w = scl_fall && cnt_reg == 4'h0 && state_reg == seq_smbus_pkg::ST_READ;
	assign pec_ok = rx_byte == crc_reg;

	always_ff @(posedge clk)
	begin
		if (rst || start_cond || stop_cond)
			cnt_reg <= 4'h0;
		else if (scl_rise)
			cnt_reg <= (cnt_reg == seq_smbus_pkg::ACK_BIT) ? 4'h0 : cnt_reg + 4'h1;
	end

	// Reads of 0x90 see the live config, not the RAM shadow
	assign ram_rd = !seq_smbus_pkg::is_ram(ptr_reg) ? 8'h00 :
		(ptr_reg[7:0] == seq_smbus_pkg::CFG_ADDR) ? cfg_reg : ram_mem[ptr_reg[7:0]];
	assign rd_byte = seq_smbus_pkg::is_ram(ptr_reg) ? ram_rd :
		seq_smbus_pkg::is_nv_hi(ptr_reg[15:8]) ? nv.rdata : 8'h00; // R15 R1

	// Byte decisions, taken at the fall that opens the acknowledge slot
	always_comb
	begin
		ack = 1'b0;
		st_next = seq_smbus_pkg::ST_IGNORE;
		ptr_next = ptr_reg;
		ram_we = 1'b0;
		ram_wa = ptr_reg[7:0];
		nv_prog = 1'b0;
		nv_erase = 1'b0;
		unique case (state_reg)
			seq_smbus_pkg::ST_ADDR:
			begin
				if (rx_byte[7:1] == own_addr && !nv.erase_busy) // R22 R7
				begin
					if (!rx_byte[0])
						st_next = seq_smbus_pkg::ST_CMD;
					else
						st_next = seq_smbus_pkg::ST_READ;
					ack = !rx_byte[0] || !nv_locked(ptr_reg, run_sync[1]); // R23
				end
			end
			seq_smbus_pkg::ST_CMD:
			begin
				st_next = seq_smbus_pkg::ST_DATA;
				ack = 1'b1;
				if (rx_byte <= seq_smbus_pkg::RAM_LAST)
					ptr_next = {8'h00, rx_byte}; // R5
				else if (rx_byte == seq_smbus_pkg::CMD_ERASE)
					nv_erase = cfg_reg[seq_smbus_pkg::CFG_ERASE_EN_BIT]; // R4 R6 R7
				else if (!seq_smbus_pkg::is_nv_hi(rx_byte) && rx_byte != seq_smbus_pkg::CMD_BLK_WR
					&& rx_byte != seq_smbus_pkg::CMD_BLK_RD)
					ack = 1'b0;
			end
			seq_smbus_pkg::ST_DATA:
			begin
				if (cmd_reg <= seq_smbus_pkg::RAM_LAST)
				begin
					if (dcnt_reg == 6'h00)
					begin
						ack = 1'b1;
						// Only at the byte's end; rx_byte is still shifting before it
						ram_we = byte_done_w; // R8 R1
						ram_wa = cmd_reg;
					end
					else if (dcnt_reg == 6'h01)
						ack = pec_ok; // R18
				end
				else if (seq_smbus_pkg::is_nv_hi(cmd_reg))
				begin
					if (dcnt_reg == 6'h00)
					begin
						ptr_next = {cmd_reg, rx_byte}; // R9
						ack = !nv_locked({cmd_reg, rx_byte}, run_sync[1]); // R23
					end
					else if (dcnt_reg == 6'h01)
					begin
						ack = 1'b1;
						nv_prog = 1'b1; // R11
					end
					else if (dcnt_reg == 6'h02)
						ack = pec_ok; // R18
				end
				else if (cmd_reg == seq_smbus_pkg::CMD_BLK_WR)
				begin
					if (dcnt_reg == 6'h00)
						ack = rx_byte <= {2'b00, seq_smbus_pkg::BLK_MAX}; // R12
					else if (dcnt_reg <= blk_len_reg)
					begin
						if (seq_smbus_pkg::is_ram(ptr_reg))
						begin
							ack = 1'b1;
							ram_we = byte_done_w;
						end
						else if (seq_smbus_pkg::is_nv_hi(ptr_reg[15:8]) && !nv_locked(ptr_reg, run_sync[1]))
						begin
							ack = 1'b1;
							nv_prog = 1'b1;
						end
						if (ack)
							ptr_next = ptr_reg + 16'h0001; // R24
					end
					else if (dcnt_reg == blk_len_reg + 6'h01)
						ack = pec_ok; // R18
				end
				if (ack)
					st_next = seq_smbus_pkg::ST_DATA;
			end
			seq_smbus_pkg::ST_IDLE, seq_smbus_pkg::ST_READ, seq_smbus_pkg::ST_IGNORE:
				st_next = state_reg;
		endcase
	end

	// Next byte to send: data for a receive byte; count, data, then the running check value for a block read
	always_comb
	begin
		rd_next = seq_smbus_pkg::ERASED;
		ptr_rd_next = ptr_reg;
		if (!blk_rd_reg)
		begin
			if (rd_idx_reg == 6'h00)
				rd_next = rd_byte; // R15
		end
		else if (rd_idx_reg == 6'h00)
			rd_next = seq_smbus_pkg::BLK_COUNT; // R16
		else if (rd_idx_reg <= seq_smbus_pkg::BLK_MAX)
		begin
			rd_next = rd_byte;
			ptr_rd_next = ptr_reg + 16'h0001; // R24
		end
		else if (rd_idx_reg == seq_smbus_pkg::BLK_PEC_IDX)
			rd_next = crc_reg; // R18 R19
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg <= seq_smbus_pkg::ST_IDLE;
			cmd_reg <= 8'h00;
			ptr_reg <= 16'h0000;
			dcnt_reg <= 6'h00;
			blk_len_reg <= 6'h00;
			blk_rd_reg <= 1'b0;
			rd_idx_reg <= 6'h00;
			tx_reg <= 8'h00;
		end
		else if (start_cond)
			state_reg <= seq_smbus_pkg::ST_ADDR;
		else if (stop_cond)
		begin
			state_reg <= seq_smbus_pkg::ST_IDLE;
			blk_rd_reg <= 1'b0;
		end
		else if (byte_done_w && write_dir)
		begin
			state_reg <= st_next;
			ptr_reg <= ptr_next;
			if (state_reg == seq_smbus_pkg::ST_ADDR)
				rd_idx_reg <= 6'h00;
			if (state_reg == seq_smbus_pkg::ST_CMD)
			begin
				cmd_reg <= rx_byte;
				dcnt_reg <= 6'h00;
				blk_rd_reg <= rx_byte == seq_smbus_pkg::CMD_BLK_RD; // R16
			end
			if (state_reg == seq_smbus_pkg::ST_DATA)
			begin
				dcnt_reg <= dcnt_reg + 6'h01;
				if (cmd_reg == seq_smbus_pkg::CMD_BLK_WR && dcnt_reg == 6'h00)
					blk_len_reg <= rx_byte[5:0];
			end
		end
		else if (read_load_w)
		begin
			tx_reg <= rd_next;
			ptr_reg <= ptr_rd_next;
			if (rd_idx_reg != seq_smbus_pkg::RD_IDX_SAT)
				rd_idx_reg <= rd_idx_reg + 6'h01;
		end
		else if (scl_rise && cnt_reg == seq_smbus_pkg::ACK_BIT && state_reg == seq_smbus_pkg::ST_READ
			&& sda_sync[1])
			state_reg <= seq_smbus_pkg::ST_IGNORE; // R17 R20 R21
	end

	// Check value covers every byte of the frame, address bytes included
	always_ff @(posedge clk)
	begin
		if (rst || (start_cond && state_reg == seq_smbus_pkg::ST_IDLE))
			crc_reg <= 8'h00; // R25
		else if (byte_done_w && write_dir)
			crc_reg <= seq_smbus_pkg::crc8_step(crc_reg, rx_byte); // R19 R25
		else if (read_load_w)
			crc_reg <= seq_smbus_pkg::crc8_step(crc_reg, rd_next); // R25
	end

	// Data bits change only while SCL is low
	always_ff @(posedge clk)
	begin
		if (rst || start_cond || stop_cond)
			sda_oe_reg <= 1'b0;
		else if (scl_fall)
		begin
			if (cnt_reg == seq_smbus_pkg::ACK_BIT)
				sda_oe_reg <= ack && write_dir;
			else if (read_load_w)
				sda_oe_reg <= !rd_next[7];
			else if (state_reg == seq_smbus_pkg::ST_READ)
				sda_oe_reg <= !tx_reg[3'h7 - cnt_reg[2:0]];
			else
				sda_oe_reg <= 1'b0;
		end
	end

	// Stretch only once SCL is already low, so no short clock pulse appears
	always_ff @(posedge clk)
	begin
		if (rst)
			scl_oe_reg <= 1'b0;
		else
			scl_oe_reg <= nv.prog_busy && (scl_oe_reg || !scl_sync[1]); // R14
	end

	always_ff @(posedge clk)
	begin
		if (ram_we && ram_wa <= seq_smbus_pkg::RAM_LAST)
			ram_mem[ram_wa] <= rx_byte; // R1
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cfg_reg <= seq_smbus_pkg::CFG_RESET;
		else if (ram_we && ram_wa == seq_smbus_pkg::CFG_ADDR)
			cfg_reg <= rx_byte;
	end

	assign nv.addr = ptr_reg[9:0];
	assign nv.wdata = rx_byte;
	assign nv.prog = nv_prog && byte_done_w;
	assign nv.erase = nv_erase && byte_done_w && state_reg == seq_smbus_pkg::ST_CMD;
	assign sda_oe = sda_oe_reg;
	assign sda_out = 1'b0;
	assign scl_oe = scl_oe_reg;
	assign scl_out = 1'b0;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence byte_end_s;
		scl_fall && cnt_reg == seq_smbus_pkg::ACK_BIT;
	endsequence
	sequence read_load_s;
		scl_fall && cnt_reg == 4'h0 && state_reg == seq_smbus_pkg::ST_READ;
	endsequence

	a_addr_match_only: assert property ( // R22
		byte_end_s ##0 (state_reg == seq_smbus_pkg::ST_ADDR && rx_byte[7:1] != own_addr) |=> !sda_oe)
		else $error("acknowledged a foreign address");
	a_erase_nack_busy: assert property ( // R7
		byte_end_s ##0 (state_reg == seq_smbus_pkg::ST_ADDR && nv.erase_busy) |=> !sda_oe)
		else $error("acknowledged during page erase");
	a_erase_gate_bit: assert property ( // R4
		nv.erase |-> cfg_reg[seq_smbus_pkg::CFG_ERASE_EN_BIT] && ptr_reg[9:0] == nv.addr)
		else $error("erase issued with erase enable clear");
	a_locked_read_nack: assert property ( // R23
		byte_end_s ##0 (state_reg == seq_smbus_pkg::ST_ADDR && rx_byte[0] && nv_locked(ptr_reg, run_sync[1]))
		|=> !sda_oe)
		else $error("acknowledged locked range read");
	a_ram_byte_store: assert property ( // R8
		ram_we && ram_wa <= seq_smbus_pkg::RAM_LAST |=> ram_mem[$past(ram_wa)] == $past(rx_byte))
		else $error("register byte not stored");
	a_ptr_block_step: assert property ( // R24
		byte_end_s ##0 (state_reg == seq_smbus_pkg::ST_DATA && cmd_reg == seq_smbus_pkg::CMD_BLK_WR
		&& dcnt_reg != 6'h00 && dcnt_reg <= blk_len_reg && ack) |=> ptr_reg == $past(ptr_reg) + 16'h0001)
		else $error("pointer did not advance");
	a_scl_stretch_prog: assert property ( // R14
		nv.prog_busy && !scl_sync[1] |=> scl_oe ##1 (scl_oe || !nv.prog_busy))
		else $error("clock not held during programming");
	a_blk_count_byte: assert property ( // R16
		read_load_s ##0 (blk_rd_reg && rd_idx_reg == 6'h00)
		|=> tx_reg == seq_smbus_pkg::BLK_COUNT && sda_oe != seq_smbus_pkg::BLK_COUNT[7])
		else $error("block read count byte wrong");
	a_pec_byte_sent: assert property ( // R19
		read_load_s ##0 (blk_rd_reg && rd_idx_reg == seq_smbus_pkg::BLK_PEC_IDX) |=> tx_reg == $past(crc_reg))
		else $error("check byte differs from running CRC");
endmodule

/* tb/smbus_master_model.sv */
// SMBus master model: pulls SCL and SDA low on its own 32 ns tick clock.
// Assumes the bench resolves both wires with pull-ups.
module smbus_master_model (
	input  wire logic scl_w,
	input  wire logic sda_w,
	output logic      scl_low,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PH = 10;
	logic       tick;
	logic [7:0] got;
	int         stretch_n;
	event       got_ev;

	initial
	begin
		tick = 1'b0;
		scl_low = 1'b0;
		sda_low = 1'b0;
		stretch_n = 0;
		forever #16 tick = ~tick;
	end

	task automatic t(input int n);
		repeat (n) @(posedge tick);
	endtask

	// Slave may stretch SCL; bounded so a stuck line cannot hang us
	task automatic rise();
		int n;
		n = 0;
		scl_low <= 1'b0;
		t(1);
		while (scl_w !== 1'b1 && n < 2000)
		begin
			n++;
			t(1);
		end
		stretch_n += n;
		t(PH);
	endtask

	// Data changes mid low phase, well clear of the SDA hold window
	task automatic bit_io(input logic b, output logic r);
		t(PH);
		sda_low <= ~b;
		t(PH);
		rise();
		r = sda_w;
		scl_low <= 1'b1;
	endtask

	task automatic start(input logic rep);
		if (rep)
		begin
			t(PH);
			sda_low <= 1'b0;
			t(PH);
			rise();
		end
		sda_low <= 1'b1;
		t(PH);
		scl_low <= 1'b1;
	endtask

	task automatic stop();
		t(PH);
		sda_low <= 1'b1;
		t(PH);
		rise();
		sda_low <= 1'b0;
		t(PH);
	endtask

	task automatic wr_byte(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		got = {7'h00, r};
		->got_ev;
	endtask

	task automatic rd_byte(input logic last);
		logic [7:0] d;
		logic       r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
		got = d;
		->got_ev;
	endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the SMBus memory port, driven by a master model.
// Assumes shortened program and erase times and pull-ups on SCL and SDA.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ERASE_N = 400;
	logic        clk;
	logic        rst;
	logic        sel_hi;
	logic        sel_lo;
	logic        seq_running;
	logic        scl_out;
	logic        scl_oe;
	logic        sda_out;
	logic        sda_oe;
	logic        m_scl_low;
	logic        m_sda_low;
	wire         scl_w;
	wire         sda_w;
	logic [7:0]  q[$];
	logic [7:0]  want;
	logic [7:0]  pec;
	logic [7:0]  aw;
	logic [7:0]  a;
	logic [7:0]  d1;
	logic [7:0]  d3;
	logic [7:0]  b[3];
	logic [31:0] seed;
	int          errors;
	int          n_checks;

`define CHECK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("unexpected at %0t got %h expected %h", $time, g, e); end end

	assign scl_w = m_scl_low ? 1'b0 : (scl_oe ? scl_out : 1'b1);
	assign sda_w = m_sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);

	smbus_master_model m (.scl_w(scl_w), .sda_w(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low));

	seq_smbus_top #(.PROG_CYC(20), .ERASE_CYC(ERASE_N)) dut_u (
		.clk(clk), .rst(rst), .scl_clk(scl_w), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .bus_addr_select_hi(sel_hi),
		.bus_addr_select_lo(sel_lo), .seq_running(seq_running));

	function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
		c = c ^ d;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
		return c;
	endfunction

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic pins(input logic hi, input logic lo, input logic run);
		@(posedge clk);
		sel_hi <= hi;
		sel_lo <= lo;
		seq_running <= run;
		repeat (4) @(posedge clk);
	endtask

	task automatic go(input logic rep);
		if (!rep)
			pec = 8'h00;
		m.start(rep);
	endtask

	task automatic wr(input logic [7:0] v, input logic nack);
		q.push_back({7'h00, nack});
		pec = crc(pec, v);
		m.wr_byte(v);
	endtask

	task automatic rd(input logic [7:0] v, input logic last);
		q.push_back(v);
		pec = crc(pec, v);
		m.rd_byte(last);
	endtask

	// Write frame of n bytes after the address; byte nk is the first refused
	task automatic wf(input int n, input logic [7:0] c, x, y, input logic [1:0] pm, input int nk);
		logic [7:0] v[4];
		v = '{aw, c, x, y};
		go(1'b0);
		for (int i = 0; i <= n && i <= nk; i++)
			wr(v[i], i == nk);
		if (pm != 2'd0 && nk > n)
			wr(pm == 2'd1 ? pec : ~pec, pm == 2'd2);
		m.stop();
	endtask

	task automatic peek(input logic [7:0] e);
		go(1'b0);
		wr(aw | 8'h01, 1'b0);
		rd(e, 1'b1);
		m.stop();
	endtask

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		forever
		begin
			@(m.got_ev);
			want = q.pop_front();
			`CHECK(m.got, want)
		end
	end

	// Whole run is near 1.5 ms of bus traffic
	initial
	begin
		#4ms;
		errors++;
		end_of_test();
	end

	initial
	begin
		rst = 1'b1;
		sel_hi = 1'b0;
		sel_lo = 1'b0;
		seq_running = 1'b0;
		seed = 32'd70941;
		errors = 0;
		n_checks = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			pins(i[1], i[0], 1'b0);
			aw = {5'h11, ~i[1:0], 1'b0};
			wf(1, 8'h00, 8'h00, 8'h00, 2'd0, 0);
			aw = {5'h11, i[1:0], 1'b0};
			wf(1, 8'h10, 8'h00, 8'h00, 2'd0, 9);
		end
		$display("test address done");
		for (int k = 0; k < 4; k++)
		begin
			a = (k == 3) ? 8'hdf : rnd() % 8'h8f;
			d1 = rnd();
			wf(2, a, d1, 8'h00, 2'd1, 9);
			wf(1, a, 8'h00, 8'h00, 2'd0, 9);
			peek(d1);
		end
		wf(2, 8'h20, d1, 8'h00, 2'd2, 3);
		wf(1, 8'he5, 8'h00, 8'h00, 2'd0, 1);
		$display("test registers done");
		wf(2, 8'h90, 8'h00, 8'h00, 2'd0, 9);
		d1 = rnd();
		d3 = rnd();
		wf(3, 8'hf8, 8'h40, d1, 2'd1, 9);
		wf(3, 8'hf8, 8'h3f, d3, 2'd0, 9);
		wf(3, 8'hf8, 8'h40, ~d1, 2'd0, 9);
		wf(2, 8'hf8, 8'h40, 8'h00, 2'd0, 9);
		peek(d1);
		wf(1, 8'hfe, 8'h00, 8'h00, 2'd0, 9);
		repeat (ERASE_N) @(posedge clk);
		peek(d1);
		wf(2, 8'h90, 8'h04, 8'h00, 2'd0, 9);
		wf(1, 8'h90, 8'h00, 8'h00, 2'd0, 9);
		peek(8'h04);
		wf(2, 8'hf8, 8'h5f, 8'h00, 2'd0, 9);
		wf(1, 8'hfe, 8'h00, 8'h00, 2'd0, 9);
		wf(1, 8'h00, 8'h00, 8'h00, 2'd0, 0);
		repeat (ERASE_N) @(posedge clk);
		wf(2, 8'hf8, 8'h40, 8'h00, 2'd0, 9);
		peek(8'hff);
		wf(2, 8'hf8, 8'h3f, 8'h00, 2'd0, 9);
		peek(d3);
		$display("test erase done");
		wf(2, 8'hf8, 8'h5e, 8'h00, 2'd0, 9);
		m.stretch_n = 0;
		go(1'b0);
		wr(aw, 1'b0);
		wr(8'hfc, 1'b0);
		wr(8'h03, 1'b0);
		foreach (b[j])
		begin
			b[j] = rnd();
			wr(b[j], 1'b0);
		end
		m.stop();
		`CHECK(m.stretch_n > 0, 1'b1)
		wf(2, 8'hf8, 8'h5c, 8'h00, 2'd0, 9);
		go(1'b0);
		wr(aw, 1'b0);
		wr(8'hfd, 1'b0);
		go(1'b1);
		wr(aw | 8'h01, 1'b0);
		rd(8'h20, 1'b0);
		for (int j = 0; j < 32; j++)
			rd((j >= 2 && j < 5) ? b[j - 2] : 8'hff, 1'b0);
		rd(pec, 1'b1);
		m.stop();
		$display("test block done");
		wf(2, 8'hfc, 8'h21, 8'h00, 2'd0, 2);
		wf(2, 8'hfa, 8'h00, 8'h00, 2'd0, 9);
		pins(1'b1, 1'b1, 1'b1);
		go(1'b0);
		wr(aw | 8'h01, 1'b1);
		m.stop();
		wf(2, 8'hfa, 8'h00, 8'h00, 2'd0, 2);
		pins(1'b1, 1'b1, 1'b0);
		$display("test refusals done");
		end_of_test();
	end
endmodule
